/* core/twsc_spi_shift.sv */
// SPI slave byte shifter with pin synchronisers for the touch-wheel sensor
`timescale 1ns/1ps
`include "twsc_map.svh"

module twsc_spi_shift (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              ss_n_pin,
    input  wire logic              sclk_pin,
    input  wire logic              mosi_pin,
    input  wire logic              enable,
    input  wire twsc_pkg::twsc_byte_t tx_byte,
    output logic                   ss_low,
    output logic                   ss_fall,
    output logic                   ss_rise,
    output logic                   sclk_edge,
    output twsc_pkg::twsc_byte_t   rx_byte,
    output logic                   rx_valid,
    output logic                   miso,
    output logic                   miso_oe
);
    import twsc_pkg::*;

    // ----------------------------------------------------------------
    // Synchronisers: stage a feeds stage b only
    // ----------------------------------------------------------------
    logic [2:0] sync_a_r;
    logic [2:0] sync_b_r;
    logic [2:0] sync_c_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_a_r <= 3'h7;
            sync_b_r <= 3'h7;
            sync_c_r <= 3'h7;
        end else begin
            sync_a_r <= {ss_n_pin, sclk_pin, mosi_pin};
            sync_b_r <= sync_a_r;
            sync_c_r <= sync_b_r;
        end
    end

    logic sclk_rise;
    logic sclk_fall;

    assign ss_low    = ~sync_b_r[2];
    assign ss_fall   = sync_c_r[2] & ~sync_b_r[2];
    assign ss_rise   = ~sync_c_r[2] & sync_b_r[2];
    assign sclk_rise = ~sync_c_r[1] & sync_b_r[1];
    assign sclk_fall = sync_c_r[1] & ~sync_b_r[1];
    assign sclk_edge = sclk_rise | sclk_fall;

    // ----------------------------------------------------------------
    // Shift registers
    // ----------------------------------------------------------------
    twsc_byte_t tx_sh_r, tx_sh_nxt;
    twsc_byte_t rx_sh_r, rx_sh_nxt;
    twsc_byte_t rx_byte_nxt;
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic       valid_r, valid_nxt;
    logic       miso_r, miso_nxt;

    // Mode 3 framing: drive on falling, sample on rising, MSB first
    always_comb begin
        tx_sh_nxt   = tx_sh_r;
        rx_sh_nxt   = rx_sh_r;
        rx_byte_nxt = rx_byte;
        bit_cnt_nxt = bit_cnt_r;
        valid_nxt   = 1'b0;
        miso_nxt    = miso_r;
        if (ss_fall || !ss_low || !enable) begin
            tx_sh_nxt   = tx_byte;
            bit_cnt_nxt = 3'h0;
            miso_nxt    = tx_byte[7];
        end else begin
            if (sclk_fall) begin
                miso_nxt  = tx_sh_r[7];
                tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
            end
            if (sclk_rise) begin
                rx_sh_nxt   = {rx_sh_r[6:0], sync_b_r[0]};
                bit_cnt_nxt = bit_cnt_r + 3'h1;
                if (bit_cnt_r == 3'(`TWSC_SPI_BITS - 1)) begin
                    rx_byte_nxt = {rx_sh_r[6:0], sync_b_r[0]};
                    valid_nxt   = 1'b1;
                    tx_sh_nxt   = tx_byte;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh_r   <= 8'h00;
            rx_sh_r   <= 8'h00;
            rx_byte   <= 8'h00;
            bit_cnt_r <= 3'h0;
            valid_r   <= 1'b0;
            miso_r    <= 1'b0;
        end else begin
            tx_sh_r   <= tx_sh_nxt;
            rx_sh_r   <= rx_sh_nxt;
            rx_byte   <= rx_byte_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            valid_r   <= valid_nxt;
            miso_r    <= miso_nxt;
        end
    end

    assign rx_valid = valid_r;
    assign miso     = miso_r;
    // Released whenever select is high so other slaves can share the line
    assign miso_oe  = ss_low & enable;
endmodule

/* core/twsc_top.sv */
// Control, sleep and status logic of the touch-wheel sensor
`timescale 1ns/1ps
`include "twsc_map.svh"

// Overview of operation
// - After an SPI transfer, sleep until slave-select rises; host may extend sleep.
// - On wake by slave-select rise, float proximity and talk-permit pins ~400 us.
// - On wake by slave-select rise clamp slave-select low three cycles (250 ns rounded up); host drives it open-drain.
// - Serial clock activity wakes the device, which then waits for slave-select rise.
// - Proximity output high while hand sensed; also bit 0 of untouched response.
// - Seven-bit position reported only while touched; 0/127, 43, 85 at terminals.
// - Position updates on each touched burst and clears to 0 when touch is lost.
// - Calibrate after rst_n (power-up) and on command 0x01; no other input triggers it.
// - Calibration runs ten bursts, 1.5 ms apart, without further host commands.
// - During calibration refuse communication and hold talk-permit low.
// - Error bit 1 set when untouched and signal fell well below reference.
// - Drift compensation only on drift command; calibration command clears error.
// - Wait 500 us after wake before a burst; no wait without preceding sleep.
// - Sync mode: after slave-select falls then rises, do one acquisition burst.
// - Slave-select high: acquire every ~60 ms without sleeping.
// - Eight-bit transfers, MSB first, clock idles high, drive falling, sample rising.
module twsc_top #(
    parameter int SETTLE_CYC  = (`TWSC_SETTLE_US * 1000) / `TWSC_CLK_NS,
    parameter int CAL_GAP_CYC = (`TWSC_CAL_GAP_US * 1000) / `TWSC_CLK_NS,
    parameter int FREE_CYC    = (`TWSC_FREE_MS * 1000000) / `TWSC_CLK_NS,
    parameter int CAL_BURSTS  = `TWSC_CAL_BURSTS
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              ss_n_in,
    output logic                   ss_n_out,
    output logic                   ss_n_oe,
    input  wire logic              sclk_in,
    input  wire logic              mosi_in,
    output logic                   miso_out,
    output logic                   miso_oe,
    output logic                   prox_out,
    output logic                   prox_oe,
    output logic                   host_talk_permit_out,
    output logic                   host_talk_permit_oe,
    output logic                   acq_start,
    output logic                   acq_cal,
    output logic                   drift_step,
    input  wire logic              acq_done,
    input  wire logic              fe_touch,
    input  wire logic              fe_prox,
    input  wire twsc_pkg::twsc_pos_t fe_pos,
    input  wire logic              fe_below_ref,
    output logic                   cal_busy,
    output logic                   sleeping,
    output logic                   touch_flag,
    output logic                   error_flag,
    output twsc_pkg::twsc_pos_t    pos_value
);
    import twsc_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic twsc_byte_t resp_byte(input logic touch, input logic prox,
                                             input logic err, input twsc_pos_t pos);
        twsc_byte_t b;
        b = 8'h00;
        if (touch) begin
            b = {1'b1, pos};
        end else begin
            b[`TWSC_RSP_PROX_BIT] = prox;
            b[`TWSC_RSP_ERR_BIT]  = err;
        end
        return b;
    endfunction

    function automatic logic cnt_done(input twsc_cnt_t cnt, input int limit);
        return cnt >= twsc_cnt_t'(limit - 1);
    endfunction

    // ----------------------------------------------------------------
    // SPI shifter
    // ----------------------------------------------------------------
    logic       ss_low;
    logic       ss_fall_raw;
    logic       ss_rise_raw;
    logic       sclk_edge;
    twsc_byte_t rx_byte;
    logic       rx_valid;
    logic       ss_fall;
    logic       ss_rise;
    logic       talk_en;
    twsc_byte_t tx_byte;

    logic       touch_r, touch_nxt;
    logic       prox_r, prox_nxt;
    logic       err_r, err_nxt;
    twsc_pos_t  pos_r, pos_nxt;

    twsc_state_e state_r, state_nxt;
    logic [2:0]  clamp_cnt_r, clamp_cnt_nxt;

    assign talk_en = ~cal_busy;
    assign tx_byte = resp_byte(touch_r, prox_r, err_r, pos_r);

    twsc_spi_shift u_shift (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .ss_n_pin  (ss_n_in),
        .sclk_pin  (sclk_in),
        .mosi_pin  (mosi_in),
        .enable    (talk_en),
        .tx_byte   (tx_byte),
        .ss_low    (ss_low),
        .ss_fall   (ss_fall_raw),
        .ss_rise   (ss_rise_raw),
        .sclk_edge (sclk_edge),
        .rx_byte   (rx_byte),
        .rx_valid  (rx_valid),
        .miso      (miso_out),
        .miso_oe   (miso_oe)
    );

    // Our own clamp pulse must not be mistaken for a host frame
    assign ss_fall = ss_fall_raw & (clamp_cnt_r == 3'h0);
    assign ss_rise = ss_rise_raw & (clamp_cnt_r == 3'h0);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    twsc_cnt_t   cnt_r, cnt_nxt;
    logic [3:0]  burst_r, burst_nxt;
    logic        cal_pend_r, cal_pend_nxt;
    logic        start_r, start_nxt;
    logic        drift_r, drift_nxt;
    logic        wake_pulse;
    logic        launch;

    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        burst_nxt    = burst_r;
        cal_pend_nxt = cal_pend_r;
        start_nxt    = 1'b0;
        drift_nxt    = 1'b0;
        wake_pulse   = 1'b0;
        launch       = 1'b0;
        case (state_r)
            ST_BOOT: begin
                cal_pend_nxt = 1'b1;
                launch       = 1'b1;
            end
            ST_CAL_ACQ: begin
                if (acq_done) begin
                    burst_nxt = burst_r + 4'h1;
                    cnt_nxt   = '0;
                    if (burst_r == 4'(CAL_BURSTS - 1)) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        state_nxt = ST_CAL_GAP;
                    end
                end
            end
            ST_CAL_GAP: begin
                cnt_nxt = cnt_r + 20'h00001;
                if (cnt_done(cnt_r, CAL_GAP_CYC)) begin
                    state_nxt = ST_CAL_ACQ;
                    start_nxt = 1'b1;
                    cnt_nxt   = '0;
                end
            end
            ST_IDLE: begin
                cnt_nxt = cnt_r + 20'h00001;
                if (ss_fall) begin
                    state_nxt = ST_FRAME;
                end else if (cnt_done(cnt_r, FREE_CYC)) begin
                    launch = 1'b1;
                end
            end
            ST_FRAME: begin
                if (rx_valid) begin
                    state_nxt = ST_SLEEP;
                end else if (ss_rise) begin
                    launch = 1'b1;
                end
            end
            ST_SLEEP: begin
                if (ss_rise) begin
                    state_nxt  = ST_SETTLE;
                    wake_pulse = 1'b1;
                    cnt_nxt    = '0;
                end else if (sclk_edge) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (rx_valid) begin
                    state_nxt = ST_SLEEP;
                end else if (ss_rise) begin
                    state_nxt = ST_SETTLE;
                    cnt_nxt   = '0;
                end
            end
            ST_SETTLE: begin
                cnt_nxt = cnt_r + 20'h00001;
                if (cnt_done(cnt_r, SETTLE_CYC)) begin
                    launch = 1'b1;
                end
            end
            ST_ACQ: begin
                if (acq_done) begin
                    state_nxt = ST_IDLE;
                    cnt_nxt   = '0;
                end
            end
            default: begin
                state_nxt = ST_BOOT;
            end
        endcase
        if (launch) begin
            start_nxt = 1'b1;
            cnt_nxt   = '0;
            if (cal_pend_nxt) begin
                state_nxt    = ST_CAL_ACQ;
                burst_nxt    = 4'h0;
                cal_pend_nxt = 1'b0;
            end else begin
                state_nxt = ST_ACQ;
            end
        end
        // Commands after the clear so a late byte is never lost
        if (rx_valid && talk_en) begin
            if (rx_byte == `TWSC_CMD_CAL) begin
                cal_pend_nxt = 1'b1;
            end
            if (rx_byte == `TWSC_CMD_DRIFT) begin
                drift_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= ST_BOOT;
            cnt_r      <= '0;
            burst_r    <= 4'h0;
            cal_pend_r <= 1'b0;
            start_r    <= 1'b0;
            drift_r    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            burst_r    <= burst_nxt;
            cal_pend_r <= cal_pend_nxt;
            start_r    <= start_nxt;
            drift_r    <= drift_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Burst results
    // ----------------------------------------------------------------
    always_comb begin
        touch_nxt = touch_r;
        prox_nxt  = prox_r;
        err_nxt   = err_r;
        pos_nxt   = pos_r;
        if (acq_done && state_r == ST_CAL_ACQ) begin
            err_nxt = 1'b0;
        end else if (acq_done && state_r == ST_ACQ) begin
            touch_nxt = fe_touch;
            prox_nxt  = fe_prox;
            pos_nxt   = fe_touch ? fe_pos : 7'h00;
            err_nxt   = ~fe_touch & fe_below_ref;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            touch_r <= 1'b0;
            prox_r  <= 1'b0;
            err_r   <= 1'b0;
            pos_r   <= 7'h00;
        end else begin
            touch_r <= touch_nxt;
            prox_r  <= prox_nxt;
            err_r   <= err_nxt;
            pos_r   <= pos_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Wake float and diagnostic clamp
    // ----------------------------------------------------------------
    logic [11:0] float_cnt_r, float_cnt_nxt;

    always_comb begin
        float_cnt_nxt = float_cnt_r;
        clamp_cnt_nxt = clamp_cnt_r;
        if (wake_pulse) begin
            float_cnt_nxt = 12'(`TWSC_FLOAT_CYC);
            clamp_cnt_nxt = 3'(`TWSC_CLAMP_CYC + `TWSC_CLAMP_GUARD);
        end else begin
            if (float_cnt_r != 12'h000) begin
                float_cnt_nxt = float_cnt_r - 12'h001;
            end
            if (clamp_cnt_r != 3'h0) begin
                clamp_cnt_nxt = clamp_cnt_r - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            float_cnt_r <= 12'h000;
            clamp_cnt_r <= 3'h0;
        end else begin
            float_cnt_r <= float_cnt_nxt;
            clamp_cnt_r <= clamp_cnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign ss_n_out             = 1'b0;
    // Guard cycles let the synchronised pin recover before frames count
    assign ss_n_oe              = clamp_cnt_r > 3'(`TWSC_CLAMP_GUARD);
    assign prox_out             = prox_r;
    assign prox_oe              = float_cnt_r == 12'h000;
    assign host_talk_permit_out = ~cal_busy;
    assign host_talk_permit_oe  = float_cnt_r == 12'h000;
    assign cal_busy             = (state_r == ST_CAL_ACQ) || (state_r == ST_CAL_GAP) || (state_r == ST_BOOT);
    assign acq_cal              = cal_busy;
    assign acq_start            = start_r;
    assign drift_step           = drift_r;
    assign sleeping             = state_r == ST_SLEEP;
    assign touch_flag           = touch_r;
    assign error_flag           = err_r;
    assign pos_value            = pos_r;
endmodule

/* shared/twsc_map.svh */
// Offsets, codes and timing counts of the touch-wheel sensor control block
`ifndef TWSC_MAP_SVH
`define TWSC_MAP_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define TWSC_CLK_NS        100
`define TWSC_FLOAT_US      400
`define TWSC_FLOAT_CYC     ((`TWSC_FLOAT_US * 1000) / `TWSC_CLK_NS)
`define TWSC_CLAMP_NS      250
`define TWSC_CLAMP_CYC     ((`TWSC_CLAMP_NS + `TWSC_CLK_NS - 1) / `TWSC_CLK_NS)
`define TWSC_CLAMP_GUARD   4
`define TWSC_SETTLE_US     500
`define TWSC_CAL_GAP_US    1500
`define TWSC_FREE_MS       60
`define TWSC_CAL_BURSTS    10

// ----------------------------------------------------------------
// Commands and response fields
// ----------------------------------------------------------------
`define TWSC_CMD_CAL       8'h01
`define TWSC_CMD_DRIFT     8'h03
`define TWSC_RSP_TOUCH_BIT 7
`define TWSC_RSP_PROX_BIT  0
`define TWSC_RSP_ERR_BIT   1
`define TWSC_SPI_BITS      8

`endif

/* shared/twsc_pkg.sv */
// Types shared by the touch-wheel sensor control block
package twsc_pkg;
    typedef logic [7:0] twsc_byte_t;
    typedef logic [6:0] twsc_pos_t;
    typedef logic [19:0] twsc_cnt_t;

    typedef enum logic [3:0] {
        ST_BOOT,
        ST_CAL_ACQ,
        ST_CAL_GAP,
        ST_IDLE,
        ST_FRAME,
        ST_SLEEP,
        ST_WAKE,
        ST_SETTLE,
        ST_ACQ
    } twsc_state_e;
endpackage

/* verification/tb_top.sv */
// Self-checking bench for the touch-wheel sensor control block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin failures++; \
    $display("wrong value %s expected %h seen %h", nm, e, a); end end
`define WAIT(c, n) begin waited = 0; while (!(c) && waited < (n)) begin \
    @(posedge clk_sys); waited++; end if (!(c)) begin failures++; wrap_up(); end end
module tb_top;
    import twsc_pkg::*;
    localparam int SETTLE = 20;
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       ss_low_drv, sclk_pin, mosi_pin, miso_out, miso_oe, miso_q = 1'b0;
    logic       ss_n_out, ss_n_oe, prox_out, prox_oe, hp_out, hp_oe, acq_cal;
    logic       acq_start, drift_step, cal_busy, sleeping, touch_flag, error_flag;
    logic       acq_done = 1'b0, fe_touch = 1'b0, fe_prox = 1'b0, fe_below_ref = 1'b0;
    twsc_pos_t  fe_pos = 7'h00, pos_value;
    twsc_pos_t  pos_tab [4] = '{7'h7f, 7'h00, 7'h55, 7'h2b};
    twsc_byte_t rx;
    int         fe_cnt = 0, n_start = 0, n_drift = 0, n_clamp = 0;
    int         waited, failures = 0, checked = 0, b0, c0, i;
    wire        ss_n_in = !(ss_low_drv | (ss_n_oe & !ss_n_out));
    wire        prox_pin = prox_oe ? prox_out : 1'b0;
    wire        miso_line = miso_oe ? miso_out : ~miso_q;
    always #50 clk_sys = ~clk_sys;
    // ------------------------
    // Front end stand-in, six-cycle bursts
    // ------------------------
    always @(posedge clk_sys) begin
        if (miso_oe) miso_q <= miso_out;
        n_start  <= n_start + int'(acq_start);
        n_drift  <= n_drift + int'(drift_step);
        n_clamp  <= n_clamp + int'(ss_n_oe);
        fe_cnt   <= acq_start ? 6 : ((fe_cnt > 0) ? fe_cnt - 1 : 0);
        acq_done <= (fe_cnt == 1);
    end
    twsc_host twsc_host_inst (.clk_sys(clk_sys), .miso_line(miso_line), .ss_low_drv(ss_low_drv),
        .sclk_pin(sclk_pin), .mosi_pin(mosi_pin));
    twsc_top #(.SETTLE_CYC(SETTLE), .CAL_GAP_CYC(20), .FREE_CYC(100), .CAL_BURSTS(10)) twsc_top_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe),
        .sclk_in(sclk_pin), .mosi_in(mosi_pin), .miso_out(miso_out), .miso_oe(miso_oe),
        .prox_out(prox_out), .prox_oe(prox_oe), .host_talk_permit_out(hp_out), .host_talk_permit_oe(hp_oe),
        .acq_start(acq_start), .acq_cal(acq_cal), .drift_step(drift_step), .acq_done(acq_done),
        .fe_touch(fe_touch), .fe_prox(fe_prox), .fe_pos(fe_pos), .fe_below_ref(fe_below_ref),
        .cal_busy(cal_busy), .sleeping(sleeping), .touch_flag(touch_flag), .error_flag(error_flag),
        .pos_value(pos_value));
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic frame(input twsc_byte_t tx, input int nbits);
        twsc_host_inst.xfer(tx, nbits, rx);
        twsc_host_inst.release_ss();
    endtask
    task automatic results();
        `WAIT(acq_done === 1'b1, 20)
        repeat (2) @(posedge clk_sys);
    endtask
    // ------------------------
    // Sequence
    // ------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        `WAIT(hp_out === 1'b1, 2000)
        `CHK("power-up bursts", 10, n_start)
        $display("test power-up done");
        fe_touch <= 1'b1;
        fe_prox  <= 1'b1;
        for (i = 0; i < 4; i++) begin
            fe_pos <= pos_tab[i];
            b0 = n_start;
            frame(8'h00, 0);
            `WAIT(n_start != b0, 30)
            `CHK("no settle", 1'b1, waited < SETTLE)
            results();
            `CHK("position", pos_tab[i], pos_value)
            `CHK("touch", 1'b1, touch_flag)
        end
        $display("test sync frames done");
        b0 = n_drift;
        twsc_host_inst.xfer(8'h03, 8, rx);
        `CHK("touched response", 8'hab, rx)
        `CHK("asleep", 1'b1, sleeping)
        `CHK("drift pulses", 1, n_drift - b0)
        c0 = n_clamp;
        b0 = n_start;
        twsc_host_inst.release_ss();
        `WAIT(n_start != b0, 200)
        `CHK("settle", 1'b1, waited >= SETTLE)
        `CHK("clamp cycles", 3, n_clamp - c0)
        `CHK("float level", 1'b0, prox_pin)
        `WAIT(prox_oe === 1'b1, 5000)
        `CHK("prox level", 1'b1, prox_pin)
        $display("test drift and wake done");
        fe_touch     <= 1'b0;
        fe_below_ref <= 1'b1;
        b0 = n_start;
        frame(8'h00, 0);
        `WAIT(n_start != b0, 30)
        results();
        `CHK("untouched pos", 7'h00, pos_value)
        `CHK("error flag", 1'b1, error_flag)
        twsc_host_inst.xfer(8'h00, 8, rx);
        `CHK("untouched response", 8'h03, rx)
        twsc_host_inst.kick();
        `CHK("clock wake", 1'b0, sleeping)
        c0 = n_clamp;
        b0 = n_start;
        twsc_host_inst.release_ss();
        `WAIT(n_start != b0, 200)
        `CHK("no clamp", 0, n_clamp - c0)
        `CHK("settle", 1'b1, waited >= SETTLE)
        $display("test untouched done");
        b0 = n_start;
        frame(8'h01, 8);
        `WAIT(cal_busy === 1'b1, 200)
        c0 = n_drift;
        frame(8'h03, 8);
        `CHK("refused drift", 0, n_drift - c0)
        `CHK("permit in cal", 2'b01, {hp_out, acq_cal})
        `WAIT(cal_busy === 1'b0, 3000)
        `CHK("command bursts", 10, n_start - b0)
        `CHK("error cleared", 1'b0, error_flag)
        `WAIT(prox_oe === 1'b1, 5000)
        $display("test calibrate done");
        b0 = n_start;
        `WAIT(n_start == b0 + 1, 400)
        `WAIT(n_start == b0 + 2, 400)
        `CHK("free-run gap", 1'b1, waited >= 100 && waited <= 115)
        `CHK("awake", 1'b0, sleeping)
        $display("test free run done");
        wrap_up();
    end
endmodule

/* verification/twsc_host.sv */
// Host SPI master model facing the touch-wheel sensor
`timescale 1ns/1ps
module twsc_host (
    input  wire logic clk_sys,
    input  wire logic miso_line,
    output logic      ss_low_drv,
    output logic      sclk_pin,
    output logic      mosi_pin
);
    import twsc_pkg::*;
    initial begin
        ss_low_drv = 1'b0;
        sclk_pin   = 1'b1;
        mosi_pin   = 1'b0;
    end
    // 800 ns serial clock: four system cycles per half
    task automatic half();
        repeat (4) @(posedge clk_sys);
    endtask
    // Select only ever pulled low, so the device clamp cannot fight it
    task automatic xfer(input twsc_byte_t tx, input int nbits, output twsc_byte_t rx);
        int i;
        rx = 8'h00;
        @(posedge clk_sys);
        ss_low_drv <= 1'b1;
        repeat (12) @(posedge clk_sys);
        for (i = 7; i >= 8 - nbits; i--) begin
            sclk_pin <= 1'b0;
            mosi_pin <= tx[i];
            half();
            sclk_pin <= 1'b1;
            rx[i] = miso_line;
            half();
        end
        mosi_pin <= ~mosi_pin;
        repeat (20) @(posedge clk_sys);
    endtask
    task automatic release_ss();
        ss_low_drv <= 1'b0;
    endtask
    task automatic kick();
        sclk_pin <= 1'b0;
        half();
        sclk_pin <= 1'b1;
        half();
    endtask
endmodule

/* verification/twsc_top_chk.sv */
// Concurrent checks on the ports of the touch-wheel sensor control block
`timescale 1ns/1ps
module twsc_top_chk #(
    parameter int SETTLE_CYC = 20
) (
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                ss_n_in,
    input wire logic                ss_n_out,
    input wire logic                ss_n_oe,
    input wire logic                miso_oe,
    input wire logic                prox_oe,
    input wire logic                host_talk_permit_out,
    input wire logic                host_talk_permit_oe,
    input wire logic                acq_start,
    input wire logic                drift_step,
    input wire logic                cal_busy,
    input wire logic                sleeping,
    input wire logic                touch_flag,
    input wire twsc_pkg::twsc_pos_t pos_value
);
    import twsc_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ------------------------
    // Float and wake timers
    // ------------------------
    logic [12:0] flt_r, flt_nxt;
    logic [15:0] wk_r, wk_nxt;
    logic        woke_r, woke_nxt;
    always_comb begin
        flt_nxt  = prox_oe ? 13'h0 : flt_r + 13'h1;
        wk_nxt   = sleeping ? 16'h0 : wk_r + 16'(wk_r != 16'hffff);
        woke_nxt = sleeping | (woke_r & ~acq_start);
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flt_r  <= 13'h0;
            wk_r   <= 16'h0;
            woke_r <= 1'b0;
        end else begin
            flt_r  <= flt_nxt;
            wk_r   <= wk_nxt;
            woke_r <= woke_nxt;
        end
    end
    // ------------------------
    // Properties
    // ------------------------
    perm_cal_a: assert property (cal_busy |-> !host_talk_permit_out)
        else $error("permit high in calibration");
    miso_cal_a: assert property (cal_busy |-> !miso_oe)
        else $error("data out driven in calibration");
    clamp_len_a: assert property ($rose(ss_n_oe) |-> ss_n_oe[*3] ##1 !ss_n_oe)
        else $error("select clamp not three cycles");
    clamp_low_a: assert property (ss_n_oe |-> !ss_n_out)
        else $error("select clamp drives high");
    wake_clamp_a: assert property ((sleeping && $rose(ss_n_in)) |-> ##[1:6] ss_n_oe)
        else $error("no clamp after wake by select");
    float_len_a: assert property ($rose(prox_oe) |-> flt_r inside {[13'd3999:13'd4001]})
        else $error("float interval wrong length");
    oe_pair_a: assert property (prox_oe == host_talk_permit_oe)
        else $error("float enables differ");
    pos_zero_a: assert property (!touch_flag |-> pos_value == 7'h00)
        else $error("position shown without touch");
    settle_wait_a: assert property ((acq_start && woke_r) |-> wk_r >= SETTLE_CYC - 1)
        else $error("burst too soon after wake");
    drift_pulse_a: assert property (drift_step |=> !drift_step)
        else $error("drift pulse too long");
    acq_pulse_a: assert property (acq_start |=> !acq_start)
        else $error("burst start too long");
    cover property ($rose(ss_n_oe));
    cover property ($fell(cal_busy));
    cover property (drift_step);
endmodule

bind twsc_top twsc_top_chk #(.SETTLE_CYC(SETTLE_CYC)) twsc_top_chk_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe),
    .miso_oe(miso_oe), .prox_oe(prox_oe), .host_talk_permit_out(host_talk_permit_out),
    .host_talk_permit_oe(host_talk_permit_oe), .acq_start(acq_start), .drift_step(drift_step),
    .cal_busy(cal_busy), .sleeping(sleeping), .touch_flag(touch_flag), .pos_value(pos_value));
